/* rtl/demod_timing_cfg.svh */
`ifndef DEMOD_TIMING_CFG_SVH
`define DEMOD_TIMING_CFG_SVH

// ==========================================================
// Register offsets
`define ADDR_RX_TIMING_A        5'h04
`define ADDR_RX_TIMING_B        5'h05
`define ADDR_OUTPUT_PIN_CTRL    5'h06

// ==========================================================
// Field positions
`define BIT_CHECK_MSB           7
`define BIT_CHECK_LSB           6
`define LIM_MIN_MSB             5
`define LIM_MIN_LSB             0
`define RATE_RANGE_MSB          7
`define RATE_RANGE_LSB          6
`define LIM_MAX_MSB             5
`define LIM_MAX_LSB             0
`define OUT_SOURCE_BIT          7
`define OUT_LEVEL_BIT           6

// ==========================================================
// Reset values
`define RST_RX_TIMING_A         8'h4b
`define RST_RX_TIMING_B         8'ha0
`define RST_OUTPUT_PIN_CTRL     8'h00

// ==========================================================
// Timing counts in demodulator clock periods
`define DUPLEX_BIT_PERIOD       8'ha8
`define DIV_RANGE0              5'h08
`define DIV_RANGE1              5'h04
`define DIV_RANGE2              5'h02
`define DIV_RANGE3              5'h01

// ==========================================================
// Bit-check counts per code
`define CHECK_BITS0             4'h0
`define CHECK_BITS1             4'h3
`define CHECK_BITS2             4'h6
`define CHECK_BITS3             4'h9

`endif

/* rtl/demod_timing_pkg.sv */
package demod_timing_pkg;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_RX,
        MODE_TX,
        MODE_DUPLEX_MASTER,
        MODE_DUPLEX_SLAVE
    } op_mode_e;

    typedef enum logic [1:0] {
        CHK_IDLE,
        CHK_ARM,
        CHK_RUN
    } check_state_e;

endpackage

/* rtl/edge_interval_checker.sv */
`timescale 1ns/1ps

module edge_interval_checker (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       enable,
    input  wire logic       start,
    input  wire logic       edge_seen,
    input  wire logic       tick,
    input  wire logic [5:0] lim_min,
    input  wire logic [5:0] lim_max,
    input  wire logic [3:0] bits_needed,
    output logic            busy,
    output logic            pass,
    output logic            fail
);

    demod_timing_pkg::check_state_e state;
    demod_timing_pkg::check_state_e next_state;
    logic [6:0]                     interval;
    logic [6:0]                     next_interval;
    logic [3:0]                     passed;
    logic [3:0]                     next_passed;
    logic                           next_pass;
    logic                           next_fail;

    // ==========================================================
    // Interval window
    wire logic [6:0] interval_inc = (interval == 7'h7f) ? interval : interval + 7'h01;
    wire logic       too_short    = interval < {1'b0, lim_min};
    wire logic       too_long     = interval_inc >= {1'b0, lim_max};
    wire logic [3:0] passed_inc   = passed + 4'h1;

    always_comb begin
        next_state    = state;
        next_interval = interval;
        next_passed   = passed;
        next_pass     = 1'b0;
        next_fail     = 1'b0;
        case (state)
            demod_timing_pkg::CHK_IDLE: begin
                if (start && enable) begin
                    next_interval = 7'h00;
                    next_passed   = 4'h0;
                    if (bits_needed == 4'h0) begin
                        next_pass = 1'b1;
                    end else begin
                        next_state = demod_timing_pkg::CHK_ARM;
                    end
                end
            end
            // First edge opens the first interval
            demod_timing_pkg::CHK_ARM: begin
                if (!enable) begin
                    next_state = demod_timing_pkg::CHK_IDLE;
                end else if (edge_seen) begin
                    next_interval = 7'h00;
                    next_state    = demod_timing_pkg::CHK_RUN;
                end
            end
            demod_timing_pkg::CHK_RUN: begin
                if (!enable) begin
                    next_state = demod_timing_pkg::CHK_IDLE;
                end else if (edge_seen) begin
                    next_interval = 7'h00;
                    if (too_short) begin
                        next_fail  = 1'b1;
                        next_state = demod_timing_pkg::CHK_IDLE;
                    end else if (passed_inc == bits_needed) begin
                        next_pass  = 1'b1;
                        next_state = demod_timing_pkg::CHK_IDLE;
                    end else begin
                        next_passed = passed_inc;
                    end
                end else if (tick) begin
                    next_interval = interval_inc;
                    if (too_long) begin
                        next_fail  = 1'b1;
                        next_state = demod_timing_pkg::CHK_IDLE;
                    end
                end
            end
            default: begin
                next_state = demod_timing_pkg::CHK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state    <= demod_timing_pkg::CHK_IDLE;
            interval <= 7'h00;
            passed   <= 4'h0;
            pass     <= 1'b0;
            fail     <= 1'b0;
        end else begin
            state    <= next_state;
            interval <= next_interval;
            passed   <= next_passed;
            pass     <= next_pass;
            fail     <= next_fail;
        end
    end

    assign busy = (state != demod_timing_pkg::CHK_IDLE);

    // ==========================================================
    // Checks
    a_short_interval_fails: assert property (
        @(posedge clk) disable iff (!rstn)
        (state == demod_timing_pkg::CHK_RUN && enable && edge_seen && interval < {1'b0, lim_min})
        |=> fail && !pass
    ) else $error("short interval not failed");

    a_long_interval_fails: assert property (
        @(posedge clk) disable iff (!rstn)
        (state == demod_timing_pkg::CHK_RUN && enable && !edge_seen && tick && too_long)
        |=> fail && !busy
    ) else $error("long interval not failed");

    a_zero_bits_pass: assert property (
        @(posedge clk) disable iff (!rstn)
        (state == demod_timing_pkg::CHK_IDLE && start && enable && bits_needed == 4'h0)
        |=> pass && !busy
    ) else $error("zero-bit check did not pass at once");

endmodule // edge_interval_checker

/* rtl/demod_timing_config_regs.sv */
// What this block does
// - Bit-check code selects 0, 3, 6, 9 bits
// - Check fields ignored in TX, duplex master
// - Lower limit is value times extended period
// - Upper limit is value minus one periods
// - Range code divides demod clock by 8/4/2/1
// - Range codes map to nominal rate bands
// - Duplex with range 1 runs 168-clock bits
// - Select low drives pin from level bit
// - Select high shows active-low receive indication
// - Scale bit doubles extended period and limits
`timescale 1ns/1ps
`include "demod_timing_cfg.svh"

module demod_timing_config_regs (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [4:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wr_data,
    output logic      [7:0]                  reg_rd_data,
    output logic                             reg_rd_valid,
    input  wire demod_timing_pkg::op_mode_e  op_mode,
    input  wire logic                        ext_limit_en,
    input  wire logic                        rx_data_in,
    input  wire logic                        bit_check_start,
    output logic                             bit_check_busy,
    output logic                             bit_check_pass,
    output logic                             bit_check_fail,
    output logic                             ext_clock_tick,
    output logic                             duplex_bit_tick,
    output logic                             general_output_pin
);

    logic [7:0] rx_timing_control_a;
    logic [7:0] rx_timing_control_b;
    logic [1:0] output_pin_control;
    logic [4:0] div_cnt;
    logic [7:0] duplex_cnt;
    logic       rx_s1;
    logic       rx_s2;
    logic       rx_s3;
    logic       rx_level;

    // ==========================================================
    // Register decode
    wire logic hit_a   = (reg_addr == `ADDR_RX_TIMING_A);
    wire logic hit_b   = (reg_addr == `ADDR_RX_TIMING_B);
    wire logic hit_out = (reg_addr == `ADDR_OUTPUT_PIN_CTRL);
    wire logic [7:0] out_ctrl_rst = `RST_OUTPUT_PIN_CTRL;

    wire logic [7:0] rd_mux =
        hit_a   ? rx_timing_control_a :
        hit_b   ? rx_timing_control_b :
        hit_out ? {output_pin_control, 6'h00} :
        8'h00;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_timing_control_a <= `RST_RX_TIMING_A;
            rx_timing_control_b <= `RST_RX_TIMING_B;
            output_pin_control  <= out_ctrl_rst[`OUT_SOURCE_BIT:`OUT_LEVEL_BIT];
        end else if (reg_wr_en) begin
            if (hit_a) begin
                rx_timing_control_a <= reg_wr_data;
            end else if (hit_b) begin
                rx_timing_control_b <= reg_wr_data;
            end else if (hit_out) begin
                output_pin_control <= reg_wr_data[`OUT_SOURCE_BIT:`OUT_LEVEL_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rd_data  <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Fields
    wire logic [1:0] check_code  = rx_timing_control_a[`BIT_CHECK_MSB:`BIT_CHECK_LSB];
    wire logic [5:0] lim_min     = rx_timing_control_a[`LIM_MIN_MSB:`LIM_MIN_LSB];
    wire logic [1:0] rate_range  = rx_timing_control_b[`RATE_RANGE_MSB:`RATE_RANGE_LSB];
    wire logic [5:0] lim_max     = rx_timing_control_b[`LIM_MAX_MSB:`LIM_MAX_LSB];
    wire logic       out_source  = output_pin_control[1];
    wire logic       out_level   = output_pin_control[0];

    wire logic [3:0] bits_needed =
        (check_code == 2'h0) ? `CHECK_BITS0 :
        (check_code == 2'h1) ? `CHECK_BITS1 :
        (check_code == 2'h2) ? `CHECK_BITS2 :
        `CHECK_BITS3;

    // ==========================================================
    // Extended data clock
    wire logic [4:0] div_base =
        (rate_range == 2'h0) ? `DIV_RANGE0 :
        (rate_range == 2'h1) ? `DIV_RANGE1 :
        (rate_range == 2'h2) ? `DIV_RANGE2 :
        `DIV_RANGE3;
    wire logic [4:0] div_period = ext_limit_en ? {div_base[3:0], 1'b0} : div_base;
    wire logic       div_wrap   = (div_cnt >= div_period - 5'h01);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_cnt        <= 5'h00;
            ext_clock_tick <= 1'b0;
        end else begin
            div_cnt        <= div_wrap ? 5'h00 : div_cnt + 5'h01;
            ext_clock_tick <= div_wrap;
        end
    end

    // ==========================================================
    // Full-duplex bit clock
    wire logic duplex_mode = (op_mode == demod_timing_pkg::MODE_DUPLEX_MASTER) ||
                             (op_mode == demod_timing_pkg::MODE_DUPLEX_SLAVE);
    wire logic duplex_run  = duplex_mode && (rate_range == 2'h1);
    wire logic duplex_wrap = (duplex_cnt == `DUPLEX_BIT_PERIOD - 8'h01);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            duplex_cnt      <= 8'h00;
            duplex_bit_tick <= 1'b0;
        end else begin
            duplex_cnt      <= (!duplex_run || duplex_wrap) ? 8'h00 : duplex_cnt + 8'h01;
            duplex_bit_tick <= duplex_run && duplex_wrap;
        end
    end

    // ==========================================================
    // Receive data synchroniser and edge detect
    wire logic rx_agree = (rx_s2 == rx_s3);
    wire logic rx_edge  = rx_agree && (rx_s3 != rx_level);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_s1    <= 1'b0;
            rx_s2    <= 1'b0;
            rx_s3    <= 1'b0;
            rx_level <= 1'b0;
        end else begin
            rx_s1 <= rx_data_in;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_agree) begin
                rx_level <= rx_s3;
            end
        end
    end

    // ==========================================================
    // Bit-check
    wire logic check_enable = (op_mode == demod_timing_pkg::MODE_RX) ||
                              (op_mode == demod_timing_pkg::MODE_DUPLEX_SLAVE);

    edge_interval_checker u_checker (
        .clk         (clk),
        .rstn        (rstn),
        .enable      (check_enable),
        .start       (bit_check_start),
        .edge_seen   (rx_edge),
        .tick        (ext_clock_tick),
        .lim_min     (lim_min),
        .lim_max     (lim_max),
        .bits_needed (bits_needed),
        .busy        (bit_check_busy),
        .pass        (bit_check_pass),
        .fail        (bit_check_fail)
    );

    // ==========================================================
    // General output pin
    wire logic rx_active_n = (op_mode != demod_timing_pkg::MODE_RX);
    wire logic next_pin    = out_source ? rx_active_n : out_level;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            general_output_pin <= 1'b0;
        end else begin
            general_output_pin <= next_pin;
        end
    end

    // ==========================================================
    // Checks
    // Cycles since the last duplex tick; preset so the first bit lines up
    logic [7:0] duplex_gap;

    always_ff @(posedge clk) begin
        if (!rstn || !duplex_run) begin
            duplex_gap <= 8'hff;
        end else if (duplex_bit_tick) begin
            duplex_gap <= 8'h00;
        end else begin
            duplex_gap <= duplex_gap + 8'h01;
        end
    end

    a_pin_follows_level: assert property (
        @(posedge clk) disable iff (!rstn)
        !out_source |=> general_output_pin == $past(out_level)
    ) else $error("pin does not follow level bit");

    a_pin_shows_receive: assert property (
        @(posedge clk) disable iff (!rstn)
        out_source |=> general_output_pin == ($past(op_mode) != demod_timing_pkg::MODE_RX)
    ) else $error("pin does not show receive indication");

    a_defaults_after_reset: assert property (
        @(posedge clk)
        !rstn |=> check_code == 2'h1 && lim_min == 6'h0b && lim_max == 6'h20 && rate_range == 2'h2
                  && !general_output_pin
    ) else $error("reset defaults wrong");

    a_tick_range3: assert property (
        @(posedge clk) disable iff (!rstn)
        (ext_clock_tick && rate_range == 2'h3 && !ext_limit_en && $stable(rate_range)) |=> ext_clock_tick
    ) else $error("range 3 tick spacing wrong");

    a_tick_range2: assert property (
        @(posedge clk) disable iff (!rstn)
        (ext_clock_tick && rate_range == 2'h2 && !ext_limit_en) ##1 (rate_range == 2'h2 && !ext_limit_en)
        |-> !ext_clock_tick ##1 ext_clock_tick
    ) else $error("range 2 tick spacing wrong");

    a_tick_scaled: assert property (
        @(posedge clk) disable iff (!rstn)
        (ext_clock_tick && rate_range == 2'h3 && ext_limit_en) ##1 (rate_range == 2'h3 && ext_limit_en)
        |-> !ext_clock_tick ##1 ext_clock_tick
    ) else $error("scaled tick spacing wrong");

    a_duplex_bit_period: assert property (
        @(posedge clk) disable iff (!rstn)
        (duplex_bit_tick && $past(duplex_run)) |-> $past(duplex_gap) == 8'ha6
    ) else $error("duplex bit period not 168 clocks");

    a_check_off_in_tx: assert property (
        @(posedge clk) disable iff (!rstn)
        (op_mode == demod_timing_pkg::MODE_TX || op_mode == demod_timing_pkg::MODE_DUPLEX_MASTER)
        |=> !bit_check_busy && !bit_check_pass && !bit_check_fail
    ) else $error("bit-check active outside receive");

endmodule // demod_timing_config_regs

/* dv/host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Register bus master standing in for the microcontroller
module host_model (
    input  wire logic       clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [4:0]      reg_addr,
    output logic [7:0]      reg_wr_data,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid
);
    initial begin
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = 5'h00;
        reg_wr_data = 8'h00;
    end

    // Data is inverted once released so stale values never match
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en   <= 1'b1;
        reg_addr    <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en   <= 1'b0;
        reg_wr_data <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        v = reg_rd_valid;
        d = reg_rd_data;
    endtask
endmodule // host_model

/* dv/tb_demod_timing_config_regs.sv */
`timescale 1ns/1ps

module tb_demod_timing_config_regs;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       ext = 1'b0;
    logic       rx = 1'b0;
    logic       start = 1'b0;
    logic       wr_en, rd_en, rd_valid, busy, pass, fail, xt, dt, pin, v, p, f;
    logic [4:0] addr;
    logic [7:0] wr_data, rd_data, d, w;
    int         err_total = 0;
    int         n_compared = 0;
    int         n, k;
    logic [4:0] ra [4] = '{5'h04, 5'h05, 5'h06, 5'h1f};
    logic [7:0] rv [4] = '{8'h4b, 8'ha0, 8'h00, 8'h00};
    int         lf [3] = '{10, 12, 0};
    demod_timing_pkg::op_mode_e op_mode = demod_timing_pkg::MODE_RX;

    always #5 clk = ~clk;

    host_model host (.clk(clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wr_data(wr_data), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));

    demod_timing_config_regs dut (.clk(clk), .rstn(rstn), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
        .op_mode(op_mode), .ext_limit_en(ext), .rx_data_in(rx), .bit_check_start(start),
        .bit_check_busy(busy), .bit_check_pass(pass), .bit_check_fail(fail),
        .ext_clock_tick(xt), .duplex_bit_tick(dt), .general_output_pin(pin));

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask

    task automatic test_done();
        $display("compared=%0d errors=%0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic int xd_div(input logic [1:0] c, input logic e);
        return (8 >> c) * (e ? 2 : 1);
    endfunction

    // Cycles between ticks, measured after settling on a fresh tick
    task automatic period(input logic sel, output int m);
        k = 0;
        m = 0;
        repeat (2) begin
            m = 0;
            do begin
                @(posedge clk);
                #1;
                m++;
            end while ((sel ? dt : xt) !== 1'b1 && m < 400);
        end
    endtask

    // Start a check, toggle receive data every per cycles, report outcome
    task automatic bc(input logic [1:0] c, input int per, output logic pp, output logic ff);
        host.wr(5'h04, {c, 6'h0a});
        @(posedge clk) start <= 1'b1;
        pp = 1'b0;
        ff = 1'b0;
        // Outcome is read just after each edge, from the one that takes start
        for (k = 0; k < 600 && !pp && !ff; k++) begin
            @(posedge clk);
            start <= 1'b0;
            if (k % per == per - 1)
                rx <= ~rx;
            #1;
            pp = (pass === 1'b1);
            ff = (fail === 1'b1);
        end
    endtask

    initial begin
        #300000;
        err_total++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(2));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        #1 chk(pin === 1'b0 && busy === 1'b0, "reset outputs");
        foreach (ra[i]) begin
            host.rd(ra[i], d, v);
            chk(v === 1'b1 && d === rv[i], "reset value");
        end
        repeat (6) begin
            for (int i = 0; i < 3; i++) begin
                w = {2'($urandom_range(3, 0)), 6'($urandom_range(63, lf[i]))};
                host.wr(ra[i], w);
                host.rd(ra[i], d, v);
                chk(d === (i == 2 ? {w[7:6], 6'h00} : w), "readback");
            end
        end
        host.wr(5'h1f, 8'h5a);
        host.rd(5'h1f, d, v);
        chk(v === 1'b1 && d === 8'h00, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            host.wr(5'h06, {1'b0, i[0], 6'h15});
            repeat (2) @(posedge clk);
            #1 chk(pin === i[0], "pin level");
        end
        host.wr(5'h06, 8'hc0);
        for (int m = 0; m < 5; m++) begin
            @(posedge clk) op_mode <= demod_timing_pkg::op_mode_e'(m);
            repeat (3) @(posedge clk);
            #1 chk(pin === (m != 1), "pin receive flag");
        end
        for (int c = 0; c < 8; c++) begin
            @(posedge clk) ext <= c[2];
            host.wr(5'h05, {c[1:0], 6'h20});
            period(1'b0, n);
            chk(n === xd_div(c[1:0], c[2]), "xdclk period");
        end
        @(posedge clk) ext <= 1'b0;
        op_mode <= demod_timing_pkg::MODE_DUPLEX_MASTER;
        host.wr(5'h05, 8'h60);
        period(1'b1, n);
        chk(n === 168, "fd bit period");
        for (int m = 2; m < 4; m++) begin
            @(posedge clk) op_mode <= demod_timing_pkg::op_mode_e'(m);
            start <= 1'b1;
            @(posedge clk) start <= 1'b0;
            #1 chk(busy === 1'b0, "start refused");
        end
        @(posedge clk) op_mode <= demod_timing_pkg::MODE_RX;
        host.wr(5'h05, 8'he8);
        for (int c = 0; c < 4; c++) begin
            n = (c == 0) ? 0 : (3 * c + 1) * 20;
            bc(c[1:0], 20, p, f);
            chk(p && !f && k >= n && k < n + 10, "good intervals");
        end
        bc(2'b01, 4, p, f);
        chk(f && !p, "short interval");
        bc(2'b01, 100, p, f);
        chk(f && !p, "long interval");
        @(posedge clk) op_mode <= demod_timing_pkg::MODE_DUPLEX_SLAVE;
        bc(2'b01, 20, p, f);
        chk(p && !f, "slave check");
        test_done();
    end
endmodule // tb_demod_timing_config_regs
